// ### verification/dpg_pin_model.sv
`timescale 1ns/1ps
// pin side of both ports: a driven pin shows the port value, a released pin the
// pull-up or else the level the bench puts on the board; external sources are
// taken as weaker than an enabled pull-up
module dpg_pin_model (
    input  wire dpg_pkg::dpg_pin_drv_t drv,
    input  wire logic [7:0]            pullEn,
    input  wire logic [7:0]            ext,
    output logic [7:0]                 pin
);
    // resolve each pin from its drivers
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drv.oe[i])
                pin[i] = drv.out[i];
            else if (pullEn[i])
                pin[i] = 1'b1;
            else
                pin[i] = ext[i];
        end
    end
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  memMoveWrite = 1'b0;
    logic                  primaryOscCfg = 1'b0;
    logic                  extClockMode = 1'b0;
    logic [7:0]            segDrvA = 8'h00;
    logic [7:0]            segDrvB = 8'h00;
    logic [7:0]            extA = 8'hff;
    logic [7:0]            extB = 8'h00;
    logic [7:0]            paIn;
    logic [7:0]            pbIn;
    logic [7:0]            pbPullup;
    logic [7:0]            analogEn;
    logic                  timerClockIn;
    logic                  pinChangeFlag;
    logic                  pinChangeWake;
    dpg_pkg::dpg_pin_drv_t paDrv;
    dpg_pkg::dpg_pin_drv_t pbDrv;
    int                    errCount = 0;
    int                    nCompared = 0;

    // 25 MHz system clock
    always #20 clk = ~clk;

    dpg_gpio i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memMoveWrite(memMoveWrite),
        .paIn(paIn), .paDrv(paDrv), .pbIn(pbIn), .pbDrv(pbDrv), .pbPullup(pbPullup),
        .primaryOscCfg(primaryOscCfg), .extClockMode(extClockMode),
        .segDrvA(segDrvA), .segDrvB(segDrvB), .analogEn(analogEn),
        .timerClockIn(timerClockIn), .pinChangeFlag(pinChangeFlag),
        .pinChangeWake(pinChangeWake));
    // port A has no pull-ups
    dpg_pin_model i_pins_a (.drv(paDrv), .pullEn(8'h00), .ext(extA), .pin(paIn));
    dpg_pin_model i_pins_b (.drv(pbDrv), .pullEn(pbPullup), .ext(extB), .pin(pbIn));

    task automatic finalReport();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apbXfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                           output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errCount++;
            finalReport();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apbXfer(a, 1'b1, d, q, e);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apbXfer(a, 1'b0, 32'h0, q, e);
        check(q, exp);
    endtask

    // pins follow a register write one cycle late, so let them land first
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    initial begin
        logic [7:0]  exp;
        logic [31:0] q;
        logic        e;
        int          hi;
        int          chg;
        logic        prv;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdChk(dpg_pkg::PA_LAT_OFS, 32'h0);
        rdChk(dpg_pkg::PA_DIR_OFS, 32'hff);
        rdChk(dpg_pkg::CFG_OFS, 32'h0);
        rdChk(dpg_pkg::PB_DIR_OFS, 32'hff);
        rdChk(dpg_pkg::IRQ_TWO_OFS, 32'h80);
        check(pbPullup, 32'h0);
        check(analogEn, 32'h2f);
        rdChk(dpg_pkg::PA_DATA_OFS, 32'hd0);
        wr(dpg_pkg::CFG_OFS, 32'hff);
        rdChk(dpg_pkg::CFG_OFS, 32'h3f);
        rdChk(dpg_pkg::PA_DATA_OFS, 32'hff);
        // every select code: channel k is analog below 7-k
        for (int s = 0; s < 16; s++) begin
            wr(dpg_pkg::CFG_OFS, 32'(s));
            settle();
            exp = 8'h00;
            for (int k = 0; k < 5; k++)
                exp[k == 4 ? 5 : k] = (s < 7 - k);
            check(analogEn, exp);
        end
        wr(dpg_pkg::CFG_OFS, 32'h0);
        wr(dpg_pkg::PA_DATA_OFS, 32'ha5);
        rdChk(dpg_pkg::PA_LAT_OFS, 32'ha5);
        wr(dpg_pkg::PA_DIR_OFS, 32'h0);
        settle();
        check(paDrv, 32'ha5ff);
        wr(dpg_pkg::PA_LAT_OFS, 32'hb5);
        settle();
        check(timerClockIn, 32'h1);
        // segment on pin 4 wins over latch and direction
        wr(dpg_pkg::SEG_LO_OFS, 32'h40);
        settle();
        check(paDrv.out, 32'ha5);
        wr(dpg_pkg::PA_DIR_OFS, 32'hff);
        settle();
        check(paDrv.oe, 32'h10);
        // segment drives the pin high, yet the port read must not see it
        segDrvA <= 8'h10;
        settle();
        rdChk(dpg_pkg::PA_DATA_OFS, 32'hc0);
        wr(dpg_pkg::SEG_LO_OFS, 32'h0);
        wr(dpg_pkg::PA_DIR_OFS, 32'h0);
        primaryOscCfg <= 1'b1;
        settle();
        check(paDrv.oe[7:6], 32'h0);
        wr(dpg_pkg::PA_DIR_OFS, 32'hff);
        rdChk(dpg_pkg::PA_DIR_OFS, 32'h3f);
        rdChk(dpg_pkg::PA_LAT_OFS, 32'h35);
        rdChk(dpg_pkg::PA_DATA_OFS, 32'h10);
        extClockMode <= 1'b1;
        settle();
        hi = 0;
        chg = 0;
        @(posedge clk);
        prv = paDrv.out[6];
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            hi += paDrv.out[6];
            chg += (paDrv.out[6] != prv);
            prv = paDrv.out[6];
        end
        check({paDrv.oe[6], 8'(hi), 8'(chg)}, {1'b1, 8'h04, 8'h04});
        primaryOscCfg <= 1'b0;
        extClockMode <= 1'b0;
        wr(dpg_pkg::PB_DIR_OFS, 32'h0);
        wr(dpg_pkg::PB_DATA_OFS, 32'h3c);
        settle();
        check(pbDrv, 32'h3cff);
        wr(dpg_pkg::PB_DIR_OFS, 32'hf0);
        wr(dpg_pkg::IRQ_TWO_OFS, 32'h0);
        settle();
        check(pbPullup, 32'hf0);
        wr(dpg_pkg::IRQ_TWO_OFS, 32'h80);
        wr(dpg_pkg::SEG_HI_OFS, 32'h40);
        segDrvB <= 8'h01;
        settle();
        check({pbPullup, pbDrv.out[0]}, {8'h00, 1'b1});
        wr(dpg_pkg::SEG_HI_OFS, 32'h0);
        // change detection: capture, then disturb only an output pin
        rdChk(dpg_pkg::PB_DATA_OFS, 32'h0c);
        wr(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        wr(dpg_pkg::PB_DIR_OFS, 32'he0);
        settle();
        rdChk(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        wr(dpg_pkg::PB_DIR_OFS, 32'hf0);
        settle();
        // start from a clear flag so only the input edge below can set it
        wr(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        rdChk(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        extB <= 8'h80;
        settle();
        // flag polled in irq_control_main only; a port B read would move the capture
        rdChk(dpg_pkg::IRQ_MAIN_OFS, 32'h1);
        check({pinChangeFlag, pinChangeWake}, 32'h3);
        wr(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        rdChk(dpg_pkg::IRQ_MAIN_OFS, 32'h1);
        memMoveWrite <= 1'b1;
        wr(dpg_pkg::PB_DATA_OFS, 32'h3c);
        memMoveWrite <= 1'b0;
        wr(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        rdChk(dpg_pkg::IRQ_MAIN_OFS, 32'h1);
        rdChk(dpg_pkg::PB_DATA_OFS, 32'h8c);
        wr(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        rdChk(dpg_pkg::IRQ_MAIN_OFS, 32'h0);
        settle();
        check(pinChangeFlag, 32'h0);
        // unmapped place answers with an error and zero data
        apbXfer(8'h30, 1'b0, 32'h0, q, e);
        check(q, 32'h0);
        check(32'(e), 32'h1);
        finalReport();
    end
endmodule

// ### verilog/dpg_gpio.sv
`timescale 1ns/1ps
module dpg_gpio (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  memMoveWrite,
    input  wire logic [7:0]            paIn,
    output dpg_pkg::dpg_pin_drv_t      paDrv,
    input  wire logic [7:0]            pbIn,
    output dpg_pkg::dpg_pin_drv_t      pbDrv,
    output logic [7:0]                 pbPullup,
    input  wire logic                  primaryOscCfg,
    input  wire logic                  extClockMode,
    input  wire logic [7:0]            segDrvA,
    input  wire logic [7:0]            segDrvB,
    output logic [7:0]                 analogEn,
    output logic                       timerClockIn,
    output logic                       pinChangeFlag,
    output logic                       pinChangeWake
);

    logic [7:0] port_a_output_latch_r;
    logic [7:0] dirA_r;
    logic [7:0] port_b_output_latch_r;
    logic [7:0] dirB_r;
    logic [7:0] cfg_r;
    logic [7:0] segLo_r;
    logic [7:0] segMid_r;
    logic [7:0] segHi_r;
    logic       pullupN_r;
    logic       flag_r;
    logic [3:0] pbOld_r;
    logic [dpg_pkg::CYC_CNT_W-1:0] cycCnt_r;
    logic [7:0] segA;
    logic [7:0] segB;
    logic [7:0] anaA;
    logic [7:0] oscA;
    logic [7:0] paRead;
    logic [7:0] pbRead;
    logic [3:0] selCh;
    logic       clkOutEn;
    logic       setup;
    logic       acc;
    logic       wrEn;
    logic       hit;
    logic [7:0] rdMux;
    logic       mismatch;
    logic       pbTouch;
    dpg_pkg::dpg_pin_drv_t paNxt;
    dpg_pkg::dpg_pin_drv_t pbNxt;

    // bus phases: data is fetched in setup, so access always ends in one cycle
    assign setup = psel && !penable;
    assign acc   = psel && penable && pready;
    assign wrEn  = acc && pwrite && hit;

    // segment enables mapped onto the pins they take over
    assign segA = {2'b00, segLo_r[7], segLo_r[6], 2'b00, segMid_r[2], 1'b0};
    assign segB = {2'b00, segHi_r[5], segLo_r[3:0], segHi_r[6]};

    // analog channel k is active while the select field is below 7-k
    assign selCh = cfg_r[dpg_pkg::CFG_SEL_LSB +: dpg_pkg::CFG_SEL_W];
    assign anaA  = {2'b00,
                    selCh < (dpg_pkg::ANA_NONE_SEL - 4'h4),
                    1'b0,
                    selCh < (dpg_pkg::ANA_NONE_SEL - 4'h3),
                    selCh < (dpg_pkg::ANA_NONE_SEL - 4'h2),
                    selCh < (dpg_pkg::ANA_NONE_SEL - 4'h1),
                    selCh < dpg_pkg::ANA_NONE_SEL} & ~segA;

    // primary oscillator owns the two top pins
    assign oscA     = {{2{primaryOscCfg}}, 6'h00};
    assign clkOutEn = primaryOscCfg && extClockMode;

    // digital read paths; blocked inputs read low
    assign paRead = paIn & ~segA & ~oscA & ~(anaA & dirA_r);
    assign pbRead = pbIn & ~segB;

    // only upper inputs without a segment take part in the comparison
    assign mismatch = |((pbIn[7:4] ^ pbOld_r) & dirB_r[7:4] & ~segB[7:4]);

    // a port B read or plain write ends the mismatch; memory moves do not
    assign pbTouch = acc && hit && (paddr == dpg_pkg::PB_DATA_OFS)
                     && (!pwrite || !memMoveWrite);

    // address decode and read data
    always_comb begin
        hit   = 1'b1;
        rdMux = 8'h00;
        unique case (paddr)
            dpg_pkg::PA_DATA_OFS:  rdMux = paRead;
            dpg_pkg::PA_LAT_OFS:   rdMux = port_a_output_latch_r & ~oscA;
            dpg_pkg::PA_DIR_OFS:   rdMux = dirA_r & ~oscA;
            dpg_pkg::CFG_OFS:      rdMux = {2'b00, cfg_r[dpg_pkg::CFG_IMPL_W-1:0]};
            dpg_pkg::SEG_LO_OFS:   rdMux = segLo_r;
            dpg_pkg::SEG_MID_OFS:  rdMux = segMid_r;
            dpg_pkg::SEG_HI_OFS:   rdMux = segHi_r;
            dpg_pkg::PB_DATA_OFS:  rdMux = pbRead;
            dpg_pkg::PB_LAT_OFS:   rdMux = port_b_output_latch_r;
            dpg_pkg::PB_DIR_OFS:   rdMux = dirB_r;
            dpg_pkg::IRQ_MAIN_OFS: rdMux = {7'h00, flag_r};
            dpg_pkg::IRQ_TWO_OFS:  rdMux = {pullupN_r, 7'h00};
            default: begin
                hit   = 1'b0;
                rdMux = 8'h00;
            end
        endcase
    end

    // bus answer registered in setup, ready in the single access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready  <= 1'b1;
            prdata  <= {24'h00_0000, rdMux};
            pslverr <= !hit;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // port A registers; data writes land in the latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_output_latch_r <= dpg_pkg::LAT_RST;
            dirA_r <= dpg_pkg::DIR_RST;
            cfg_r  <= dpg_pkg::CFG_RST;
        end else if (wrEn) begin
            if (paddr == dpg_pkg::PA_DATA_OFS || paddr == dpg_pkg::PA_LAT_OFS)
                port_a_output_latch_r <= pwdata[7:0];
            if (paddr == dpg_pkg::PA_DIR_OFS)
                dirA_r <= pwdata[7:0];
            if (paddr == dpg_pkg::CFG_OFS)
                cfg_r <= {2'b00, pwdata[dpg_pkg::CFG_IMPL_W-1:0]};
        end
    end

    // segment enable registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            segLo_r  <= dpg_pkg::SEG_RST;
            segMid_r <= dpg_pkg::SEG_RST;
            segHi_r  <= dpg_pkg::SEG_RST;
        end else if (wrEn) begin
            if (paddr == dpg_pkg::SEG_LO_OFS)
                segLo_r <= pwdata[7:0];
            if (paddr == dpg_pkg::SEG_MID_OFS)
                segMid_r <= pwdata[7:0];
            if (paddr == dpg_pkg::SEG_HI_OFS)
                segHi_r <= pwdata[7:0];
        end
    end

    // port B registers; a memory move still updates the latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_output_latch_r    <= dpg_pkg::LAT_RST;
            dirB_r    <= dpg_pkg::DIR_RST;
            pullupN_r <= 1'b1;
        end else if (wrEn) begin
            if (paddr == dpg_pkg::PB_DATA_OFS || paddr == dpg_pkg::PB_LAT_OFS)
                port_b_output_latch_r <= pwdata[7:0];
            if (paddr == dpg_pkg::PB_DIR_OFS)
                dirB_r <= pwdata[7:0];
            if (paddr == dpg_pkg::IRQ_TWO_OFS)
                pullupN_r <= pwdata[dpg_pkg::PULLUP_N_BIT];
        end
    end

    // comparison value follows every counted port B access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            pbOld_r <= 4'h0;
        else if (pbTouch)
            pbOld_r <= pbIn[dpg_pkg::CHG_LSB +: dpg_pkg::CHG_W];
    end

    // sticky change flag; the set term wins over a software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            flag_r <= 1'b0;
        else if (mismatch)
            flag_r <= 1'b1;
        else if (wrEn && paddr == dpg_pkg::IRQ_MAIN_OFS && !pwdata[dpg_pkg::FLAG_BIT])
            flag_r <= 1'b0;
    end

    // instruction clock divider, free running so the phase never jumps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            cycCnt_r <= '0;
        else
            cycCnt_r <= cycCnt_r + 1'b1;
    end

    // per-pin drive selection for both ports
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            if (segA[i]) begin
                paNxt.out[i] = segDrvA[i];
                paNxt.oe[i]  = 1'b1;
            end else if (oscA[i]) begin
                paNxt.out[i] = (i == dpg_pkg::OSC_LO_BIT) && clkOutEn
                               && cycCnt_r[dpg_pkg::CYC_CNT_W-1];
                paNxt.oe[i]  = (i == dpg_pkg::OSC_LO_BIT) && clkOutEn;
            end else begin
                paNxt.out[i] = port_a_output_latch_r[i];
                paNxt.oe[i]  = !dirA_r[i];
            end
            if (segB[i]) begin
                pbNxt.out[i] = segDrvB[i];
                pbNxt.oe[i]  = 1'b1;
            end else begin
                pbNxt.out[i] = port_b_output_latch_r[i];
                pbNxt.oe[i]  = !dirB_r[i];
            end
        end
    end

    // registered pin side outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            paDrv         <= '0;
            pbDrv         <= '0;
            pbPullup      <= 8'h00;
            analogEn      <= 8'h00;
            timerClockIn  <= 1'b0;
            pinChangeFlag <= 1'b0;
            pinChangeWake <= 1'b0;
        end else begin
            paDrv         <= paNxt;
            pbDrv         <= pbNxt;
            pbPullup      <= {8{!pullupN_r}} & dirB_r & ~segB;
            analogEn      <= anaA;
            timerClockIn  <= paIn[dpg_pkg::TIMER_BIT] && !segA[dpg_pkg::TIMER_BIT];
            pinChangeFlag <= flag_r;
            pinChangeWake <= flag_r;
        end
    end

    a_latch_write: assert property (@(posedge clk) disable iff (!rst_n)
        acc && pwrite && paddr == dpg_pkg::PA_DATA_OFS |=> port_a_output_latch_r == $past(pwdata[7:0]))
        else $error("port A data write did not reach latch");

    a_dir_drive: assert property (@(posedge clk) disable iff (!rst_n)
        $past(!dirB_r[0] && !segB[0]) |-> pbDrv.oe[0] && pbDrv.out[0] == $past(port_b_output_latch_r[0]))
        else $error("output pin not driving latch");

    a_analog_read: assert property (@(posedge clk) disable iff (!rst_n)
        setup && paddr == dpg_pkg::PA_DATA_OFS && anaA[0] && dirA_r[0] |=> prdata[0] == 1'b0)
        else $error("analog pin read non-zero");

    a_seg_override: assert property (@(posedge clk) disable iff (!rst_n)
        $past(segA[1]) |-> paDrv.oe[1] && paDrv.out[1] == $past(segDrvA[1]))
        else $error("segment did not take pin");

    a_osc_disable: assert property (@(posedge clk) disable iff (!rst_n)
        $past(primaryOscCfg && !clkOutEn) |-> !paDrv.oe[7] && !paDrv.oe[6])
        else $error("oscillator pins still driven");

    a_clk_out: assert property (@(posedge clk) disable iff (!rst_n)
        clkOutEn [*5] |-> paDrv.oe[6] && paDrv.out[6] != $past(paDrv.out[6], 2))
        else $error("cycle clock not at quarter rate");

    a_cfg_upper: assert property (@(posedge clk) disable iff (!rst_n)
        setup && paddr == dpg_pkg::CFG_OFS |=> prdata[7:6] == 2'b00)
        else $error("config upper bits not zero");

    a_pullup_off: assert property (@(posedge clk) disable iff (!rst_n)
        $past(!dirB_r[7]) |-> !pbPullup[7])
        else $error("pull-up on an output pin");

    a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        mismatch |=> flag_r ##1 pinChangeFlag)
        else $error("change flag not set by mismatch");

    a_move_keep: assert property (@(posedge clk) disable iff (!rst_n)
        acc && pwrite && memMoveWrite && paddr == dpg_pkg::PB_DATA_OFS |=> $stable(pbOld_r))
        else $error("memory move ended the mismatch");

    // reset defaults, looked at on the second edge after release
    a_reset_analog: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n, 2) && $past(rst_n) |-> analogEn == 8'h2f)
        else $error("analog pins not selected after reset");

    a_reset_pullup: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n, 2) && $past(rst_n) |-> pbPullup == 8'h00)
        else $error("pull-ups on after reset");

    a_select_none: assert property (@(posedge clk) disable iff (!rst_n)
        $past(selCh >= dpg_pkg::ANA_NONE_SEL) |-> analogEn == 8'h00)
        else $error("analog pin left on by digital select");

    // port A pin functions
    a_analog_out: assert property (@(posedge clk) disable iff (!rst_n)
        $past(!dirA_r[0]) |-> paDrv.oe[0] && paDrv.out[0] == $past(port_a_output_latch_r[0]))
        else $error("analog enable disturbed port A output");

    a_input_path: assert property (@(posedge clk) disable iff (!rst_n)
        setup && paddr == dpg_pkg::PA_DATA_OFS && !anaA[2] |=> prdata[2] == $past(paIn[2]))
        else $error("digital pin read not live");

    a_timer_input: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(!segA[4]) |-> timerClockIn == $past(paIn[4]))
        else $error("timer input not following pin");

    a_seg_read: assert property (@(posedge clk) disable iff (!rst_n)
        setup && paddr == dpg_pkg::PA_DATA_OFS && segA[4] |=> !prdata[4])
        else $error("segment pin read as port input");

    a_osc_input: assert property (@(posedge clk) disable iff (!rst_n)
        setup && primaryOscCfg && paddr == dpg_pkg::PA_DATA_OFS |=> prdata[7:6] == 2'b00)
        else $error("oscillator pins read as port input");

    a_osc_readback: assert property (@(posedge clk) disable iff (!rst_n)
        setup && primaryOscCfg && paddr == dpg_pkg::PA_LAT_OFS |=> prdata[7:6] == 2'b00)
        else $error("oscillator latch bits not hidden");

    a_cfg_store: assert property (@(posedge clk) disable iff (!rst_n)
        acc && pwrite && paddr == dpg_pkg::CFG_OFS |=> cfg_r[7:6] == 2'b00)
        else $error("config upper bits stored");

    // port B side
    a_port_b_output_latch_write: assert property (@(posedge clk) disable iff (!rst_n)
        acc && pwrite && paddr == dpg_pkg::PB_DATA_OFS |=> port_b_output_latch_r == $past(pwdata[7:0]))
        else $error("port B latch write lost");

    a_pb_drive: assert property (@(posedge clk) disable iff (!rst_n)
        $past(!dirB_r[5] && !segB[5]) |-> pbDrv.oe[5] && pbDrv.out[5] == $past(port_b_output_latch_r[5]))
        else $error("port B output not driving latch");

    a_pullup_on: assert property (@(posedge clk) disable iff (!rst_n)
        $past(!pullupN_r && dirB_r[6]) |-> pbPullup[6])
        else $error("pull-up missing on input pin");

    a_segb_take: assert property (@(posedge clk) disable iff (!rst_n)
        $past(segB[0]) |-> pbDrv.oe[0] && pbDrv.out[0] == $past(segDrvB[0]) && !pbPullup[0])
        else $error("segment did not take port B pin");

    a_pin_read: assert property (@(posedge clk) disable iff (!rst_n)
        setup && paddr == dpg_pkg::PB_DATA_OFS && !(|segB) |=> prdata[7:0] == $past(pbIn))
        else $error("port B read not live");

    // change flag and its compare value
    a_touch_capture: assert property (@(posedge clk) disable iff (!rst_n)
        pbTouch |=> pbOld_r == $past(pbIn[7:4]))
        else $error("port B access did not load compare value");

    a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
        flag_r && !(wrEn && paddr == dpg_pkg::IRQ_MAIN_OFS) |=> flag_r)
        else $error("change flag dropped without a clear");

    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        wrEn && paddr == dpg_pkg::IRQ_MAIN_OFS && !pwdata[dpg_pkg::FLAG_BIT] && !mismatch
        |=> !flag_r)
        else $error("change flag clear ignored");

    a_wake_follow: assert property (@(posedge clk) disable iff (!rst_n)
        $past(flag_r) |-> pinChangeWake)
        else $error("wake request missing");

    c_change_irq: cover property (@(posedge clk) disable iff (!rst_n) mismatch ##1 flag_r);
    c_flag_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(flag_r));
    c_clk_out: cover property (@(posedge clk) disable iff (!rst_n) clkOutEn [*5]);
    c_unmapped: cover property (@(posedge clk) disable iff (!rst_n) pready && pslverr);
    c_move_write: cover property (@(posedge clk) disable iff (!rst_n) acc && pwrite && memMoveWrite);

endmodule

// ### verilog/dpg_pkg.sv
// Functional notes
// - port read gives pins, write loads latch
// - direction 1 floats pin, 0 drives latch
// - reset: analog pins analog, read zero
// - four-bit field picks analog or digital
// - port A output ignores analog enable
// - analog enable blocks port A digital input; here only on pins whose direction bit is 1
// - channels 0-4 analog after power-on
// - bit 4 digital; timer input ignores direction
// - segment output overrides all pin functions
// - oscillator bit disables port A bits 6,7
// - external clock: bit 6 outputs clock/4
// - disabled bits 6,7 read undefined; here they read zero
// - config upper two bits read zero
// - port B eight bits, per-bit direction, latch
// - pull-up enable bit low enables pull-ups
// - pull-up off when pin is output
// - pull-ups off after power-on reset
// - only upper four input pins compared
// - mismatches ORed set change flag bit 0
// - mismatch keeps setting flag; access ends it
// - memory move to port B not access
// - change flag can wake the device
// - port B pins yield to enabled segments
package dpg_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] PA_DATA_OFS = 8'h00;
    localparam logic [7:0] PA_LAT_OFS  = 8'h04;
    localparam logic [7:0] PA_DIR_OFS  = 8'h08;
    localparam logic [7:0] CFG_OFS     = 8'h0c;
    localparam logic [7:0] SEG_LO_OFS  = 8'h10;
    localparam logic [7:0] SEG_MID_OFS = 8'h14;
    localparam logic [7:0] SEG_HI_OFS  = 8'h18;
    localparam logic [7:0] PB_DATA_OFS = 8'h1c;
    localparam logic [7:0] PB_LAT_OFS  = 8'h20;
    localparam logic [7:0] PB_DIR_OFS  = 8'h24;
    localparam logic [7:0] IRQ_MAIN_OFS = 8'h28;
    localparam logic [7:0] IRQ_TWO_OFS = 8'h2c;

    // reset values
    localparam logic [7:0] DIR_RST     = 8'hff;
    localparam logic [7:0] LAT_RST     = 8'h00;
    localparam logic [7:0] CFG_RST     = 8'h00;
    localparam logic [7:0] SEG_RST     = 8'h00;

    // field positions
    localparam int CFG_SEL_LSB   = 0;
    localparam int CFG_SEL_W     = 4;
    localparam int CFG_IMPL_W    = 6;
    localparam int FLAG_BIT      = 0;
    localparam int PULLUP_N_BIT  = 7;
    localparam int OSC_LO_BIT    = 6;
    localparam int TIMER_BIT     = 4;
    localparam int CHG_LSB       = 4;
    localparam int CHG_W         = 4;

    // field select value from which no channel is analog
    localparam logic [3:0] ANA_NONE_SEL = 4'h7;
    // instruction clock is the core clock over this
    localparam int CYC_DIV       = 4;
    localparam int CYC_CNT_W     = $clog2(CYC_DIV);

    // drive of one 8-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dpg_pin_drv_t;

endpackage
